// File: sima_map.vh
// Register offsets, field positions and reset values of the sensor mask and indirect window
`ifndef SIMA_MAP_VH
`define SIMA_MAP_VH
`define SIMA_PORT_SEL_ADDR 8'h4C
`define SIMA_RISE_MASK_ADDR 8'h7E
`define SIMA_FALL_MASK_ADDR 8'h7F
`define SIMA_RSVD_A0_LO 8'hA0
`define SIMA_RSVD_A0_HI 8'hA4
`define SIMA_REFCLK_ADDR 8'hA5
`define SIMA_RSVD_A7_LO 8'hA7
`define SIMA_RSVD_A7_HI 8'hAF
`define SIMA_IND_CTL_ADDR 8'hB0
`define SIMA_IND_OFS_ADDR 8'hB1
`define SIMA_IND_VAL_ADDR 8'hB2
`define SIMA_CTL_READ_BIT 0
`define SIMA_CTL_AINC_BIT 1
`define SIMA_CTL_SEL_HI 5
`define SIMA_CTL_SEL_LO 2
`define SIMA_MASK_RESET 8'h00
`define SIMA_CTL_RESET 8'h00
`define SIMA_OFS_RESET 8'h00
`define SIMA_TGT_PATGEN 4'h0
`define SIMA_TGT_PORT0 4'h1
`define SIMA_TGT_PORT1 4'h2
`define SIMA_TGT_SHARED 4'h5
`define SIMA_TGT_BOTH_PORTS 4'h6
`define SIMA_TGT_CSI 4'h7
`define SIMA_PORT_SEL_P0_BIT 0
`define SIMA_PORT_SEL_P1_BIT 1
`define SIMA_PORT_SEL_RESET 8'h01
`endif

// File: sima_regs.v
// Sensor edge interrupt masks, reference clock readout and indirect access window
//
// Behaviour
// - Per-port registers follow port select register
// - Masked rising status edge sets rise flag
// - Masked falling status edge sets fall flag
// - Reference clock shown as 8-bit MHz value
// - Target select picks internal register block
// - Code 0110 writes both port blocks together
// - Auto-increment bumps offset after each data write or data read
// - Offset write issues prefetch read strobe
// - Data read with prefetch, autoinc restrobes
// - Eight-bit offset addresses selected block register
// - Data write/read goes to selected register
`timescale 1ns/10ps
`default_nettype none
`include "sima_map.vh"
module sima_regs (
  input wire clk_in,
  input wire resetn_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  output reg reg_rvalid_out,
  input wire [7:0] sensor_status_word0_in,
  input wire [7:0] sensor_status_word1_in,
  input wire [7:0] ref_clock_mhz_value_in,
  input wire [7:0] ind_rdata_in,
  output reg [7:0] sensor_rise_latched_status0_out,
  output reg [7:0] sensor_fall_latched_status0_out,
  output reg [7:0] sensor_rise_latched_status1_out,
  output reg [7:0] sensor_fall_latched_status1_out,
  input wire [7:0] rise_clear0_in,
  input wire [7:0] fall_clear0_in,
  input wire [7:0] rise_clear1_in,
  input wire [7:0] fall_clear1_in,
  output reg sensor_irq_out,
  output reg [3:0] ind_target_out,
  output reg [7:0] ind_offset_out,
  output reg [7:0] ind_wdata_out,
  output reg ind_wr_out,
  output reg ind_rd_strobe_out,
  output reg ind_wr_both_ports_out
);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  reg [7:0] port_sel_q;
  reg [7:0] rise_mask0_q;
  reg [7:0] rise_mask1_q;
  reg [7:0] fall_mask0_q;
  reg [7:0] fall_mask1_q;
  reg [7:0] ind_ctl_q;
  reg [7:0] ind_ofs_q;
  reg [7:0] sts0_q;
  reg [7:0] sts1_q;
  reg prefetch_pend_q;

  wire sel_p0 = port_sel_q[`SIMA_PORT_SEL_P0_BIT];
  wire sel_p1 = port_sel_q[`SIMA_PORT_SEL_P1_BIT];
  wire [3:0] tgt = ind_ctl_q[`SIMA_CTL_SEL_HI:`SIMA_CTL_SEL_LO];
  wire auto_inc = ind_ctl_q[`SIMA_CTL_AINC_BIT];
  wire rd_pref = ind_ctl_q[`SIMA_CTL_READ_BIT];
  wire wr_ofs = reg_wr_in && (reg_addr_in == `SIMA_IND_OFS_ADDR);
  wire wr_val = reg_wr_in && (reg_addr_in == `SIMA_IND_VAL_ADDR);
  wire rd_val = reg_rd_in && (reg_addr_in == `SIMA_IND_VAL_ADDR);

  // Edge detect, masked per port
  wire [7:0] rise0 = sensor_status_word0_in & ~sts0_q & rise_mask0_q;
  wire [7:0] fall0 = ~sensor_status_word0_in & sts0_q & fall_mask0_q;
  wire [7:0] rise1 = sensor_status_word1_in & ~sts1_q & rise_mask1_q;
  wire [7:0] fall1 = ~sensor_status_word1_in & sts1_q & fall_mask1_q;

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  reg [7:0] rd_mux;
  always @* begin
    case (reg_addr_in)
      `SIMA_PORT_SEL_ADDR: rd_mux = port_sel_q;
      `SIMA_RISE_MASK_ADDR: rd_mux = sel_p0 ? rise_mask0_q : rise_mask1_q;
      `SIMA_FALL_MASK_ADDR: rd_mux = sel_p0 ? fall_mask0_q : fall_mask1_q;
      `SIMA_REFCLK_ADDR: rd_mux = ref_clock_mhz_value_in;
      `SIMA_IND_CTL_ADDR: rd_mux = {2'h0, ind_ctl_q[5:0]};
      `SIMA_IND_OFS_ADDR: rd_mux = ind_ofs_q;
      `SIMA_IND_VAL_ADDR: rd_mux = ind_rdata_in;
      default: rd_mux = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Registers and indirect sequencing
  // ------------------------------------------------------------
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      port_sel_q <= `SIMA_PORT_SEL_RESET;
      rise_mask0_q <= `SIMA_MASK_RESET;
      rise_mask1_q <= `SIMA_MASK_RESET;
      fall_mask0_q <= `SIMA_MASK_RESET;
      fall_mask1_q <= `SIMA_MASK_RESET;
      ind_ctl_q <= `SIMA_CTL_RESET;
      ind_ofs_q <= `SIMA_OFS_RESET;
      sts0_q <= 8'h00;
      sts1_q <= 8'h00;
      prefetch_pend_q <= 1'b0;
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
      sensor_rise_latched_status0_out <= 8'h00;
      sensor_fall_latched_status0_out <= 8'h00;
      sensor_rise_latched_status1_out <= 8'h00;
      sensor_fall_latched_status1_out <= 8'h00;
      sensor_irq_out <= 1'b0;
      ind_target_out <= 4'h0;
      ind_offset_out <= 8'h00;
      ind_wdata_out <= 8'h00;
      ind_wr_out <= 1'b0;
      ind_rd_strobe_out <= 1'b0;
      ind_wr_both_ports_out <= 1'b0;
    end else begin
      sts0_q <= sensor_status_word0_in;
      sts1_q <= sensor_status_word1_in;
      // Set wins over clear
      sensor_rise_latched_status0_out <= (sensor_rise_latched_status0_out & ~rise_clear0_in)
        | rise0;
      sensor_fall_latched_status0_out <= (sensor_fall_latched_status0_out & ~fall_clear0_in)
        | fall0;
      sensor_rise_latched_status1_out <= (sensor_rise_latched_status1_out & ~rise_clear1_in)
        | rise1;
      sensor_fall_latched_status1_out <= (sensor_fall_latched_status1_out & ~fall_clear1_in)
        | fall1;
      sensor_irq_out <= |{rise0, fall0, rise1, fall1};
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rd_mux;
      end
      if (reg_wr_in) begin
        case (reg_addr_in)
          `SIMA_PORT_SEL_ADDR: port_sel_q <= reg_wdata_in;
          `SIMA_RISE_MASK_ADDR: begin
            if (sel_p0) rise_mask0_q <= reg_wdata_in;
            if (sel_p1) rise_mask1_q <= reg_wdata_in;
          end
          `SIMA_FALL_MASK_ADDR: begin
            if (sel_p0) fall_mask0_q <= reg_wdata_in;
            if (sel_p1) fall_mask1_q <= reg_wdata_in;
          end
          `SIMA_IND_CTL_ADDR: ind_ctl_q <= {2'h0, reg_wdata_in[5:0]};
          `SIMA_IND_OFS_ADDR: ind_ofs_q <= reg_wdata_in;
          default: ;
        endcase
      end
      // Access completes: write or data read advances offset
      if ((wr_val || rd_val) && auto_inc) begin
        ind_ofs_q <= ind_ofs_q + 8'h01;
      end
      // Follow-up strobe one cycle after increment
      prefetch_pend_q <= rd_val && auto_inc && rd_pref;
      // Take a fresh select at once so the target shows one cycle after the write
      if (reg_wr_in && (reg_addr_in == `SIMA_IND_CTL_ADDR)) begin
        ind_target_out <= reg_wdata_in[`SIMA_CTL_SEL_HI:`SIMA_CTL_SEL_LO];
      end else begin
        ind_target_out <= tgt;
      end
      ind_offset_out <= wr_ofs ? reg_wdata_in : ind_ofs_q;
      ind_wdata_out <= wr_val ? reg_wdata_in : ind_wdata_out;
      ind_wr_out <= wr_val;
      ind_wr_both_ports_out <= wr_val && (tgt == `SIMA_TGT_BOTH_PORTS);
      ind_rd_strobe_out <= (wr_ofs && rd_pref) || prefetch_pend_q;
    end
  end

endmodule
`default_nettype wire

// File: sima_regs_sva.sv
// Port checker for the sensor mask and indirect window
`timescale 1ns/10ps
`default_nettype none
module sima_regs_sva (
  input wire logic clk_in, resetn_in, reg_wr_in, reg_rd_in, reg_rvalid_out, sensor_irq_out,
  input wire logic ind_wr_out, ind_rd_strobe_out, ind_wr_both_ports_out,
  input wire logic [7:0] reg_addr_in, reg_wdata_in, ind_offset_out, sensor_status_word0_in,
  input wire logic [7:0] sensor_rise_latched_status0_out, sensor_fall_latched_status0_out,
  input wire logic [3:0] ind_target_out
);
  wire ow = reg_wr_in && reg_addr_in == 8'hB1;
  wire dw = reg_wr_in && reg_addr_in == 8'hB2;
  wire dr = reg_rd_in && reg_addr_in == 8'hB2;
  wire s0 = sensor_status_word0_in[0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  chk_read_answer:
    assert property (reg_rd_in |=> reg_rvalid_out) else $error("no answer");
  chk_offset_load:
    assert property (ow |=> ind_offset_out == $past(reg_wdata_in)) else $error("bad offset");
  chk_data_write:
    assert property (dw |=> ind_wr_out) else $error("no write");
  chk_write_cause:
    assert property (ind_wr_out |-> $past(dw)) else $error("stray write");
  chk_both_ports:
    assert property (ind_wr_both_ports_out |-> ind_target_out == 4'h6) else $error("bad dual");
  chk_strobe_cause:
    assert property (ind_rd_strobe_out |-> $past(ow) || $past(dr, 2)) else $error("stray strobe");
  chk_rise_edge:
    assert property ($rose(sensor_rise_latched_status0_out[0]) |-> sensor_irq_out
      && $past(s0) && !$past(s0, 2)) else $error("rise without edge");
  chk_fall_edge:
    assert property ($rose(sensor_fall_latched_status0_out[0]) |-> sensor_irq_out
      && !$past(s0) && $past(s0, 2)) else $error("fall without edge");
  cover property (sensor_irq_out);
  cover property (ind_wr_both_ports_out);
  cover property (ind_rd_strobe_out);
endmodule
bind sima_regs sima_regs_sva sima_regs_sva_inst (.*);
`default_nettype wire

// File: sima_blk_model.sv
// Internal register block behind the indirect window
`timescale 1ns/10ps
`default_nettype none
module sima_blk_model (
  input wire logic clk_in,
  input wire logic wr_in,
  input wire logic [7:0] ofs_in,
  input wire logic [7:0] data_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  always @(posedge clk_in) begin
    if (wr_in) mem[ofs_in] <= data_in;
  end
  assign rdata_out = mem[ofs_in];
endmodule
`default_nettype wire

// File: sima_regs_bench.sv
// Bench for the sensor mask and indirect window
`timescale 1ns/10ps
`default_nettype none
module sima_regs_bench;
  logic c = 0, r = 0, w = 0, rq = 0, rv, irq, iw, sb, bo;
  logic [7:0] a = 0, d = 0, s = 0, f = 0, q, md, rr, ff, o, wo, m, n, v, x, er, ef;
  logic [3:0] t;
  int mismatches = 0, samples_checked = 0, k;
  sima_regs sima_regs_inst (.clk_in(c), .resetn_in(r), .reg_wr_in(w), .reg_rd_in(rq),
    .reg_addr_in(a), .reg_wdata_in(d), .reg_rdata_out(q), .reg_rvalid_out(rv),
    .sensor_status_word0_in(s), .sensor_status_word1_in(8'h00), .ref_clock_mhz_value_in(f),
    .ind_rdata_in(md), .sensor_rise_latched_status0_out(rr), .sensor_fall_latched_status0_out(ff),
    .sensor_rise_latched_status1_out(), .sensor_fall_latched_status1_out(),
    .rise_clear0_in(8'h00), .fall_clear0_in(8'h00), .rise_clear1_in(8'h00),
    .fall_clear1_in(8'h00), .sensor_irq_out(irq), .ind_target_out(t), .ind_offset_out(o),
    .ind_wdata_out(wo), .ind_wr_out(iw), .ind_rd_strobe_out(sb), .ind_wr_both_ports_out(bo));
  sima_blk_model sima_blk_model_inst (.clk_in(c), .wr_in(iw), .ofs_in(o), .data_in(wo),
    .rdata_out(md));
  initial forever #5 c = ~c;
  initial begin
    #300000;
    mismatches++;
    end_of_test();
  end
  task automatic cmp(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic wt, input logic [7:0] ad, dt);
    @(posedge c);
    w <= wt;
    rq <= !wt;
    a <= ad;
    d <= dt;
    @(posedge c);
    w <= 0;
    rq <= 0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] ad, e);
    acc(0, ad, 8'h00);
    cmp("read valid", 8'h01, {7'h00, rv});
    cmp("read data", e, q);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hD23D));
    f = $urandom;
    m = $urandom;
    n = $urandom;
    repeat (2) @(posedge c);
    r <= 1;
    rdc(8'h7E, 8'h00);
    rdc(8'hB0, 8'h00);
    acc(1, 8'hA5, ~f);
    rdc(8'hA5, f);
    rdc(8'hA5, f);
    acc(1, 8'h7E, m);
    acc(1, 8'h7F, n);
    acc(1, 8'h4C, 8'h02);
    acc(1, 8'h7E, ~m);
    rdc(8'h7E, ~m);
    acc(1, 8'h4C, 8'h01);
    rdc(8'h7E, m);
    $display("register test done");
    {v, er, ef} = 0;
    for (k = 0; k < 40; k++) begin
      x = (k == 3) ? 8'hFF : (k == 4) ? 8'h00 : 8'($urandom);
      @(posedge c);
      s <= x;
      @(posedge c);
      #1;
      er |= m & x & ~v;
      ef |= n & ~x & v;
      cmp("rise flags", er, rr);
      cmp("fall flags", ef, ff);
      cmp("irq", {7'h00, |((m & x & ~v) | (n & ~x & v))}, {7'h00, irq});
      v = x;
    end
    $display("edge test done");
    for (k = 0; k < 16; k++) begin
      acc(1, 8'hB0, {2'b00, k[3:0], 2'b11});
      cmp("target", {4'h0, k[3:0]}, {4'h0, t});
      if (k inside {0, 1, 2, 5, 6, 7}) begin
        x = {k[3:0], 4'h0};
        acc(1, 8'hB1, x);
        cmp("strobe", 8'h01, {7'h00, sb});
        rdc(8'hB2, x ^ 8'h5A);
        @(posedge c);
        #1;
        cmp("offset", x + 8'h01, o);
        cmp("restrobe", 8'h01, {7'h00, sb});
        v = 8'($urandom);
        acc(1, 8'hB2, v);
        cmp("dual", {7'h00, k == 6}, {7'h00, bo});
        @(posedge c);
        #1;
        cmp("written", v, sima_blk_model_inst.mem[x + 8'h01]);
      end
    end
    $display("indirect test done");
    end_of_test();
  end
endmodule
`default_nettype wire
